/* File: ccs_top.sv */
// Charger control sequencer with AXI4-Lite control and status registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module ccs_top
    import ccs_pkg::*;
#(
    parameter int unsigned VALID_CYCLES  = VALID_CYC,
    parameter int unsigned DETECT_CYCLES = DETECT_CYC,
    parameter int unsigned RCH_CYCLES    = RCH_CYC,
    parameter int unsigned BLINK_CYCLES  = BLINK_HALF_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              s_axi_awvalid,
    output      logic              s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output      logic              s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output      logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output      logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output      logic              s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    output      logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output      logic [31:0]       s_axi_rdata,
    output      logic [1:0]        s_axi_rresp,
    input  wire logic              input_above_undervolt,
    input  wire logic              input_above_overvolt,
    input  wire logic              input_below_ovp_hyst,
    input  wire logic              input_below_sleep,
    input  wire logic              battery_above_precharge,
    input  wire logic              battery_below_recharge,
    input  wire logic              current_at_termination,
    input  wire logic              battery_near_float,
    input  wire logic              output_above_bat_ovp,
    input  wire logic              battery_above_detect,
    input  wire logic              temp_at_fold,
    input  wire logic              temp_above_trip,
    input  wire logic              thermistor_hot,
    input  wire logic              thermistor_cold,
    input  wire logic              input_at_floor,
    input  wire logic              charge_inhibit,
    input  wire logic              input_limit_select,
    output      logic              test_load_en,
    output      logic              input_blocking_switch_on,
    output      logic              precharge_en,
    output      logic              pwm_en,
    output      logic              current_slew_en,
    output      logic              input_floor_hold,
    output      logic              current_fold_en,
    output      logic              detect_sink_en,
    output      logic              nobat_regulate_en,
    output      logic              reverse_block_en,
    output      logic              input_limit_high,
    output      logic              charge_indicator_o,
    output      logic              charge_indicator_oe
);
    typedef struct packed {
        logic [IN_W-1:0]   sync1;
        logic [IN_W-1:0]   sync2;
        logic              inh_prev;
        ccs_state_t        st;
        logic [2:0]        fault;
        logic              suspend;
        logic [CNT_W-1:0]  tmr;
        logic [CNT_W-1:0]  blink_cnt;
        logic              blink;
        logic              ind_en;
        logic              sw_hiz;
        logic [OUT_W-1:0]  outs;
        logic              aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_have;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } ccs_regs_t;

    ccs_regs_t        q;
    ccs_regs_t        d;
    logic [IN_W-1:0]  raw;
    logic [IN_W-1:0]  in_s;
    logic [1:0]       stat_code;
    logic [2:0]       fault_code;
    logic             charging;
    logic             active;

    assign raw = {input_limit_select, charge_inhibit, input_at_floor, thermistor_cold, thermistor_hot,
                  temp_above_trip, temp_at_fold, battery_above_detect, output_above_bat_ovp,
                  battery_near_float, current_at_termination, battery_below_recharge,
                  battery_above_precharge, input_below_sleep, input_below_ovp_hyst,
                  input_above_overvolt, input_above_undervolt};
    assign in_s = q.sync2;

    // Status and fault codes seen by software
    always_comb begin
        unique case (q.st)
            ST_HIZ, ST_VALIDATE: stat_code = STAT_READY;
            ST_PRECHG, ST_CC, ST_CV, ST_DETECT: stat_code = STAT_CHARGE;
            ST_DONE: stat_code = STAT_DONE;
            default: stat_code = STAT_FAULT;
        endcase
        if (q.suspend) begin
            stat_code = STAT_FAULT;
        end
        fault_code = q.suspend ? FLT_TSD : ((stat_code == STAT_FAULT) ? q.fault : FLT_NONE);
    end

    assign charging = (q.st == ST_PRECHG) || (q.st == ST_CC) || (q.st == ST_CV) || (q.st == ST_NOBAT);
    assign active   = (q.st != ST_HIZ) && (q.st != ST_FAULT);

    always_comb begin
        d = q;
        d.sync1    = raw;
        d.sync2    = q.sync1;
        d.inh_prev = in_s[IN_INH];

        // Trip suspends the sequencer and its pre-charge, PWM, slew, fold, floor and detect outputs; fold level low again counts as cooled
        if (in_s[IN_TRIP]) begin
            d.suspend = 1'b1;
        end else if (!in_s[IN_FOLD]) begin
            d.suspend = 1'b0;
        end

        // Sequencer and its timer are frozen as a whole while suspended
        if (!q.suspend) begin
            if (q.sw_hiz || in_s[IN_INH]) begin
                d.st  = ST_HIZ;
                d.tmr = '0;
            end else if (in_s[IN_INH] != q.inh_prev) begin
                d.st  = ST_VALIDATE;
                d.tmr = '0;
            end else if (active && in_s[IN_OVP]) begin
                d.st    = ST_FAULT;
                d.fault = FLT_OVP;
            end else if (active && !in_s[IN_UV]) begin
                d.st    = charging ? ST_FAULT : ST_HIZ;
                d.fault = FLT_POOR;
            end else if (active && in_s[IN_SLEEP]) begin
                d.st    = ST_FAULT;
                d.fault = FLT_SLEEP;
            end else if (charging && (in_s[IN_HOT] || in_s[IN_COLD])) begin
                d.st    = ST_FAULT;
                d.fault = FLT_NTC;
            end else if (charging && in_s[IN_BOVP]) begin
                d.st    = ST_FAULT;
                d.fault = FLT_BOVP;
            end else begin
                unique case (q.st)
                    ST_HIZ: begin
                        if (in_s[IN_UV]) begin
                            d.st  = ST_VALIDATE;
                            d.tmr = '0;
                        end
                    end
                    ST_VALIDATE: begin
                        // Any break in the window restarts the count
                        if (q.tmr == CNT_W'(VALID_CYCLES - 1)) begin
                            d.st    = in_s[IN_SHORT] ? ST_CC : ST_PRECHG;
                            d.fault = FLT_NONE;
                            d.tmr   = '0;
                        end else begin
                            d.tmr = q.tmr + CNT_W'(1);
                        end
                    end
                    ST_PRECHG: begin
                        if (in_s[IN_SHORT]) begin
                            d.st = ST_CC;
                        end
                    end
                    ST_CC: begin
                        if (in_s[IN_FLOAT]) begin
                            d.st = ST_CV;
                        end
                    end
                    ST_CV: begin
                        if (in_s[IN_TERM]) begin
                            d.st  = ST_DETECT;
                            d.tmr = '0;
                        end
                    end
                    ST_DETECT: begin
                        if (q.tmr == CNT_W'(DETECT_CYCLES - 1)) begin
                            d.st    = in_s[IN_DET] ? ST_DONE : ST_NOBAT;
                            d.fault = in_s[IN_DET] ? FLT_NONE : FLT_NOBAT;
                            d.tmr   = '0;
                        end else begin
                            d.tmr = q.tmr + CNT_W'(1);
                        end
                    end
                    ST_DONE: begin
                        if (!in_s[IN_RCH]) begin
                            d.tmr = '0;
                        end else if (q.tmr == CNT_W'(RCH_CYCLES - 1)) begin
                            d.st  = ST_VALIDATE;
                            d.tmr = '0;
                        end else begin
                            d.tmr = q.tmr + CNT_W'(1);
                        end
                    end
                    ST_NOBAT: begin
                        d.st = ST_NOBAT;
                    end
                    ST_FAULT: begin
                        // Every cleared fault goes back through validation
                        d.tmr = '0;
                        unique case (q.fault)
                            FLT_OVP:   if (in_s[IN_OVPCLR]) d.st = ST_VALIDATE;
                            FLT_POOR:  if (in_s[IN_UV]) d.st = ST_VALIDATE;
                            FLT_SLEEP: if (!in_s[IN_SLEEP]) d.st = ST_VALIDATE;
                            FLT_NTC:   if (!in_s[IN_HOT] && !in_s[IN_COLD]) d.st = ST_VALIDATE;
                            FLT_BOVP:  if (!in_s[IN_BOVP]) d.st = ST_VALIDATE;
                            default:   d.st = ST_VALIDATE;
                        endcase
                    end
                    default: d.st = ST_HIZ;
                endcase
            end
        end

        // Free-running blink for the fault indication
        if (q.blink_cnt == CNT_W'(BLINK_CYCLES - 1)) begin
            d.blink_cnt = '0;
            d.blink     = !q.blink;
        end else begin
            d.blink_cnt = q.blink_cnt + CNT_W'(1);
        end

        d.outs[O_LOAD]   = (q.st == ST_VALIDATE);
        d.outs[O_INSW]   = (q.st != ST_HIZ) && !((q.st == ST_FAULT) && (q.fault == FLT_OVP));
        d.outs[O_PRE]    = (q.st == ST_PRECHG) && !q.suspend;
        d.outs[O_PWM]    = ((q.st == ST_CC) || (q.st == ST_CV) || (q.st == ST_NOBAT)) && !q.suspend;
        d.outs[O_SLEW]   = (q.st == ST_CC) && !q.suspend;
        d.outs[O_FLOOR]  = d.outs[O_PWM] && in_s[IN_FLOOR];
        d.outs[O_FOLD]   = d.outs[O_PWM] && in_s[IN_FOLD];
        d.outs[O_DET]    = (q.st == ST_DETECT) && !q.suspend;
        d.outs[O_NOBAT]  = (q.st == ST_NOBAT);
        d.outs[O_REVBLK] = (q.st == ST_HIZ) || in_s[IN_SLEEP];
        d.outs[O_LIMHI]  = in_s[IN_LIM];
        d.outs[O_IND]    = (stat_code == STAT_FAULT) ? q.blink
                         : ((stat_code == STAT_CHARGE) && q.ind_en);

        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
            if (q.aw_addr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) begin
                if (q.w_strb[0]) begin
                    d.ind_en = q.w_data[CTRL_IND_EN];
                    d.sw_hiz = q.w_data[CTRL_HIZ];
                end
            end else if (q.aw_addr[ADDR_W-1:2] != REG_STATUS[ADDR_W-1:2]) begin
                d.bresp = RESP_DECERR;
            end
        end

        // AXI4-Lite read
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = '0;
            if (s_axi_araddr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) begin
                d.rdata[1:0] = {q.sw_hiz, q.ind_en};
            end else if (s_axi_araddr[ADDR_W-1:2] == REG_STATUS[ADDR_W-1:2]) begin
                d.rdata[9:0] = {q.suspend, q.st, fault_code, stat_code};
            end else begin
                d.rresp = RESP_DECERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q        <= '0;
            q.ind_en <= CTRL_RESET[CTRL_IND_EN];
            q.sw_hiz <= CTRL_RESET[CTRL_HIZ];
        end else begin
            q <= d;
        end
    end

    // One write buffered at a time; the response slot must be free
    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready  = !q.w_have && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

    assign test_load_en             = q.outs[O_LOAD];
    assign input_blocking_switch_on = q.outs[O_INSW];
    assign precharge_en             = q.outs[O_PRE];
    assign pwm_en                   = q.outs[O_PWM];
    assign current_slew_en          = q.outs[O_SLEW];
    assign input_floor_hold         = q.outs[O_FLOOR];
    assign current_fold_en          = q.outs[O_FOLD];
    assign detect_sink_en           = q.outs[O_DET];
    assign nobat_regulate_en        = q.outs[O_NOBAT];
    assign reverse_block_en         = q.outs[O_REVBLK];
    assign input_limit_high         = q.outs[O_LIMHI];
    assign charge_indicator_o       = 1'b0;
    assign charge_indicator_oe      = q.outs[O_IND];

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_precharge_excl: assert property (precharge_en |-> !pwm_en)
        else $error("precharge and pwm both on");
    a_term_detect: assert property ($past(q.st) == ST_CV && q.st == ST_DETECT |-> $past(in_s[IN_TERM]))
        else $error("detect entered without termination");
    a_valid_window: assert property ($past(q.st) == ST_VALIDATE && (q.st == ST_CC || q.st == ST_PRECHG)
        |-> $past(q.tmr) == CNT_W'(VALID_CYCLES - 1))
        else $error("charging started before validation time");
    a_poor_input: assert property ($rose(q.st == ST_FAULT) && q.fault == FLT_POOR && !q.suspend
        |-> stat_code == STAT_FAULT && fault_code == FLT_POOR)
        else $error("poor input codes wrong");
    a_ovp_switch: assert property (q.st == ST_FAULT && q.fault == FLT_OVP |=> !input_blocking_switch_on)
        else $error("blocking switch closed during over-voltage");
    a_suspend_frz: assert property (q.suspend && $past(q.suspend)
        |-> q.st == $past(q.st) && q.tmr == $past(q.tmr))
        else $error("state moved while suspended");
    a_hiz_off: assert property (q.st == ST_HIZ |=> !pwm_en && !precharge_en && !input_blocking_switch_on)
        else $error("charging circuits on in high impedance");
    a_nobat_cause: assert property ($past(q.st) == ST_DETECT && q.st == ST_NOBAT |-> !$past(in_s[IN_DET]))
        else $error("no-battery with battery above limit");
    a_bovp_stop: assert property (q.st == ST_FAULT && q.fault == FLT_BOVP |=> !pwm_en ##1 !pwm_en)
        else $error("pwm running in battery over-voltage");
    a_ind_charge: assert property (stat_code == STAT_CHARGE && q.ind_en |=> charge_indicator_oe)
        else $error("indicator not driven while charging");
    a_limit_sel: assert property (input_limit_high == $past(in_s[IN_LIM]))
        else $error("limit select not followed");
endmodule

/* File: ccs_pkg.sv */
// Constants, codes and register map of the charger control sequencer
package ccs_pkg;
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned T_VALID_MS     = 30;
    localparam int unsigned T_DETECT_MS    = 30;
    localparam int unsigned T_RCH_MS       = 30;
    localparam int unsigned BLINK_HZ       = 2;
    localparam int unsigned VALID_CYC      = CLK_HZ / 1000 * T_VALID_MS;
    localparam int unsigned DETECT_CYC     = CLK_HZ / 1000 * T_DETECT_MS;
    localparam int unsigned RCH_CYC        = CLK_HZ / 1000 * T_RCH_MS;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam int          CNT_W          = 24;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam int  CTRL_IND_EN = 0;
    localparam int  CTRL_HIZ    = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    localparam logic [1:0] STAT_READY  = 2'h0;
    localparam logic [1:0] STAT_CHARGE = 2'h1;
    localparam logic [1:0] STAT_DONE   = 2'h2;
    localparam logic [1:0] STAT_FAULT  = 2'h3;

    localparam logic [2:0] FLT_NONE  = 3'h0;
    localparam logic [2:0] FLT_OVP   = 3'h1;
    localparam logic [2:0] FLT_SLEEP = 3'h2;
    localparam logic [2:0] FLT_POOR  = 3'h3;
    localparam logic [2:0] FLT_BOVP  = 3'h4;
    localparam logic [2:0] FLT_TSD   = 3'h5;
    localparam logic [2:0] FLT_NOBAT = 3'h6;
    localparam logic [2:0] FLT_NTC   = 3'h7;

    // Synchronised comparator and pin inputs
    localparam int IN_UV = 0, IN_OVP = 1, IN_OVPCLR = 2, IN_SLEEP = 3, IN_SHORT = 4, IN_RCH = 5;
    localparam int IN_TERM = 6, IN_FLOAT = 7, IN_BOVP = 8, IN_DET = 9, IN_FOLD = 10, IN_TRIP = 11;
    localparam int IN_HOT = 12, IN_COLD = 13, IN_FLOOR = 14, IN_INH = 15, IN_LIM = 16, IN_W = 17;
    // Registered control outputs
    localparam int O_LOAD = 0, O_INSW = 1, O_PRE = 2, O_PWM = 3, O_SLEW = 4, O_FLOOR = 5;
    localparam int O_FOLD = 6, O_DET = 7, O_NOBAT = 8, O_REVBLK = 9, O_LIMHI = 10, O_IND = 11;
    localparam int OUT_W = 12;

    typedef enum logic [3:0] {
        ST_HIZ      = 4'h0,
        ST_VALIDATE = 4'h1,
        ST_PRECHG   = 4'h2,
        ST_CC       = 4'h3,
        ST_CV       = 4'h4,
        ST_DETECT   = 4'h5,
        ST_DONE     = 4'h6,
        ST_NOBAT    = 4'h7,
        ST_FAULT    = 4'h8
    } ccs_state_t;
endpackage

/* File: ccs_power_model.sv */
// Behavioural supply, battery and die model feeding the comparator inputs
`timescale 1ns/10ps
module ccs_power_model
    import ccs_pkg::*;
#(
    parameter int unsigned UV_MV = 4300, OVP_MV = 6000, HYS_MV = 150, SLP_MV = 40, SHORT_MV = 2000,
    parameter int unsigned FLOAT_MV = 4200, RCH_MV = 100, NEAR_MV = 50, BOVP_MV = 4800, DET_MV = 2000,
    parameter int unsigned TERM_MA = 100, FOLD_C = 120, TRIP_C = 145, HOT_MV = 120, COLD_MV = 900,
    parameter int unsigned FLOOR_MV = 4500
) (
    input  wire logic [15:0]     vbus_mv,
    input  wire logic [15:0]     vbat_mv,
    input  wire logic [15:0]     ichg_ma,
    input  wire logic [15:0]     die_c,
    input  wire logic [15:0]     ntc_mv,
    input  wire logic            bat_present,
    input  wire logic            inhibit,
    input  wire logic            limsel,
    input  wire logic            detect_sink_en,
    output      logic [IN_W-1:0] cmp
);
    logic [15:0] vb;
    // A missing cell collapses under the detect sink instead of holding its last voltage
    always_comb begin
        vb = (detect_sink_en && !bat_present) ? 16'h0000 : vbat_mv;
        cmp = '0;
        cmp[IN_UV] = vbus_mv > UV_MV;
        cmp[IN_OVP] = vbus_mv > OVP_MV;
        cmp[IN_OVPCLR] = vbus_mv < OVP_MV - HYS_MV;
        cmp[IN_SLEEP] = vbus_mv < vb + SLP_MV;
        cmp[IN_SHORT] = vb > SHORT_MV;
        cmp[IN_RCH] = vb < FLOAT_MV - RCH_MV;
        cmp[IN_TERM] = ichg_ma <= TERM_MA;
        cmp[IN_FLOAT] = vb > FLOAT_MV - NEAR_MV;
        cmp[IN_BOVP] = vb > BOVP_MV;
        cmp[IN_DET] = vb > DET_MV;
        cmp[IN_FOLD] = die_c >= FOLD_C;
        cmp[IN_TRIP] = die_c > TRIP_C;
        cmp[IN_HOT] = ntc_mv <= HOT_MV;
        cmp[IN_COLD] = ntc_mv >= COLD_MV;
        cmp[IN_FLOOR] = vbus_mv <= FLOOR_MV;
        cmp[IN_INH] = inhibit;
        cmp[IN_LIM] = limsel;
    end
endmodule

/* File: ccs_top_tb.sv */
// Self-checking testbench of the charger control sequencer
`timescale 1ns/10ps
module ccs_top_tb;
    import ccs_pkg::*;
    typedef struct packed {logic [15:0] vbus, vbat, ichg; logic pre, pwm; logic [1:0] st;} ccs_row_t;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, d;
    logic [15:0] vbus = 16'h0000, vbat = 16'h0E74, ichg = 16'h01F4, temp = 16'h0019, battery_thermistor = 16'h01F4;
    logic present = 1'b1, inhibit = 1'b0, limsel = 1'b0, x;
    wire logic awready, wready, bvalid, arready, rvalid, ind_o;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [IN_W-1:0] c;
    wire logic [OUT_W-1:0] o;
    int num_errors = 0, check_count = 0;
    ccs_row_t rows[5] = '{'{16'h0000, 16'h0E74, 16'h01F4, 0, 0, 2'h0}, '{16'h1388, 16'h05DC, 16'h01F4, 1, 0, 2'h1},
        '{16'h1388, 16'h0E74, 16'h01F4, 0, 1, 2'h1}, '{16'h1388, 16'h1054, 16'h0032, 0, 0, 2'h2},
        '{16'h1388, 16'h0FA0, 16'h01F4, 0, 1, 2'h1}};
    ccs_power_model PM (.vbus_mv(vbus), .vbat_mv(vbat), .ichg_ma(ichg), .die_c(temp), .ntc_mv(battery_thermistor),
        .bat_present(present), .inhibit(inhibit), .limsel(limsel), .detect_sink_en(o[O_DET]), .cmp(c));
    ccs_top #(.VALID_CYCLES(16), .DETECT_CYCLES(16), .RCH_CYCLES(16), .BLINK_CYCLES(8)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .input_above_undervolt(c[IN_UV]), .input_above_overvolt(c[IN_OVP]),
        .input_below_ovp_hyst(c[IN_OVPCLR]), .input_below_sleep(c[IN_SLEEP]), .battery_above_precharge(c[IN_SHORT]),
        .battery_below_recharge(c[IN_RCH]), .current_at_termination(c[IN_TERM]), .battery_near_float(c[IN_FLOAT]),
        .output_above_bat_ovp(c[IN_BOVP]), .battery_above_detect(c[IN_DET]), .temp_at_fold(c[IN_FOLD]),
        .temp_above_trip(c[IN_TRIP]), .thermistor_hot(c[IN_HOT]), .thermistor_cold(c[IN_COLD]),
        .input_at_floor(c[IN_FLOOR]), .charge_inhibit(c[IN_INH]), .input_limit_select(c[IN_LIM]),
        .test_load_en(o[O_LOAD]), .input_blocking_switch_on(o[O_INSW]), .precharge_en(o[O_PRE]), .pwm_en(o[O_PWM]),
        .current_slew_en(o[O_SLEW]), .input_floor_hold(o[O_FLOOR]), .current_fold_en(o[O_FOLD]),
        .detect_sink_en(o[O_DET]), .nobat_regulate_en(o[O_NOBAT]), .reverse_block_en(o[O_REVBLK]),
        .input_limit_high(o[O_LIMHI]), .charge_indicator_o(ind_o), .charge_indicator_oe(o[O_IND]));
    initial begin
        forever #20 aclk = ~aclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // The leading edge keeps a new request from landing in the step that released the last one
    task axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        chk(rresp, er);
    endtask
    task stat(input logic [1:0] st, input logic [2:0] flt);
        rd(REG_STATUS, RESP_OKAY);
        chk(d[4:0], {flt, st});
    endtask
    task settle();
        repeat (80) @(posedge aclk);
    endtask
    task restart();
        inhibit <= 1'b1; settle(); inhibit <= 1'b0; settle();
    endtask
    task report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        chk({awready, wready, arready, o}, {3'h7, 12'h000});
        aresetn <= 1'b1;
        rd(REG_CTRL, RESP_OKAY);
        chk(d, 32'h1);
        rd(8'h10, RESP_DECERR);
        axw(8'h10, 32'h3, RESP_DECERR);
        foreach (rows[i]) begin
            vbus <= rows[i].vbus; vbat <= rows[i].vbat; ichg <= rows[i].ichg; settle();
            chk({o[O_PRE], o[O_PWM]}, {rows[i].pre, rows[i].pwm});
            chk(o[O_SLEW], rows[i].pwm);
            chk(o[O_IND], rows[i].st == STAT_CHARGE);
            stat(rows[i].st, FLT_NONE);
        end
        vbus <= 16'h0FA0; settle(); stat(STAT_FAULT, FLT_POOR);
        vbus <= 16'h1388; settle(); stat(STAT_CHARGE, FLT_NONE);
        vbus <= 16'h1964; settle(); stat(STAT_FAULT, FLT_OVP);
        x = o[O_INSW]; chk(x, 1'b0);
        x = o[O_IND]; repeat (8) @(posedge aclk); chk(o[O_IND], !x);
        chk(ind_o, 1'b0);
        vbus <= 16'h1388; settle(); stat(STAT_CHARGE, FLT_NONE);
        vbus <= 16'h1130; temp <= 16'h007D; settle(); chk(o[O_FOLD], 1'b1);
        chk(o[O_FLOOR], 1'b1);
        temp <= 16'h0096; settle(); rd(REG_STATUS, RESP_OKAY); chk({d[9], o[O_PWM]}, 2'h2);
        temp <= 16'h007D; settle(); rd(REG_STATUS, RESP_OKAY); chk(d[9], 1'b1);
        temp <= 16'h0019; settle(); stat(STAT_CHARGE, FLT_NONE);
        battery_thermistor <= 16'h0064; settle(); stat(STAT_FAULT, FLT_NTC);
        battery_thermistor <= 16'h01F4; restart(); stat(STAT_CHARGE, FLT_NONE);
        vbus <= 16'h10E0; vbat <= 16'h10CC; settle(); stat(STAT_FAULT, FLT_SLEEP);
        chk(o[O_REVBLK], 1'b1);
        vbus <= 16'h1388; vbat <= 16'h1324; restart(); stat(STAT_FAULT, FLT_BOVP);
        chk(o[O_PWM], 1'b0);
        vbat <= 16'h0FA0; restart(); vbat <= 16'h1054; ichg <= 16'h0032; present <= 1'b0;
        repeat (12) @(posedge aclk); chk(o[O_DET], 1'b1);
        settle(); stat(STAT_FAULT, FLT_NOBAT);
        chk(o[O_NOBAT], 1'b1);
        // Cell back and full current again, so the restart cannot fall into detection once more
        present <= 1'b1; ichg <= 16'h01F4; restart(); chk(o[O_NOBAT], 1'b0);
        limsel <= 1'b1; settle(); chk(o[O_LIMHI], 1'b1);
        axw(REG_CTRL, 32'h3, RESP_OKAY); settle(); chk({o[O_PWM], o[O_INSW], o[O_PRE]}, 3'h0);
        axw(REG_CTRL, 32'h0, RESP_OKAY); repeat (4) @(posedge aclk); chk({o[O_LOAD], o[O_PWM]}, 2'h2);
        settle(); chk(o[O_IND], 1'b0);
        aresetn <= 1'b0; repeat (2) @(posedge aclk); chk({o[O_PWM], o[O_LOAD], o[O_IND]}, 3'h0);
        aresetn <= 1'b1; rd(REG_CTRL, RESP_OKAY); chk(d, 32'h1);
        report_and_stop();
    end
    // Whole run needs about 2300 cycles; the limit leaves margin for slow bus answers
    initial begin
        repeat (6000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end
endmodule
